// ===== acdma_top.sv
/*
  Audio capture DMA: holding register, 64-byte staging buffer, ping-pong
  SDRAM buffers, sticky flags with enables and clear bits, loopback mux.
  Assumes a serial-parallel converter outside that delivers one 32-bit
  sample per pulse, a highway that grants one request and then takes one
  word per cycle, and an APB master with 32-bit data.
*/
// Contract
// R1 - hold register then 64-byte staging buffer
// R2 - burst staging buffer while hold takes next
// R3 - arbiter latency at most sample interval minus 20ns
// R4 - bandwidth error on arrival, hold and buffer busy
// R5 - first_buffer_current reads next buffer, 1 after reset
// R6 - first fill sets flag; release refreshes buffer
// R7 - second fill sets flag; release refreshes buffer
// R8 - starved flag, enabled irq, own clear only
// R9 - bandwidth error raises irq when enabled
// R10 - reset bit resets all, reads zero
// R11 - capture_on gates capture and mastering
// R12 - stay_awake keeps running in global power down
// R13 - clear bits drop flag, read zero
// R14 - on either error discard arriving samples
// R15 - starved halt ends on any buffer release
// R16 - bandwidth halt ends when burst written
// R17 - error flags sticky until explicit clear
// R18 - loopback takes playback pins into converter
// R19 - software loopback entry sequence with soft reset
// R20 - loopback bit 0 normal, 1 diagnostic
// R21 - fill alternates between buffers without loss
// R22 - bases and size 64-aligned by software
// R23 - size counts samples, stereo pair is one
// R24 - irq is OR of enabled flags, level
`timescale 1ns/10ps

module acdma_top
  import acdma_pkg::*;
#(
  parameter int WORDS = acdma_pkg::ACDMA_BUF_WORDS
)
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sample_valid,
  input  wire logic [31:0] sample_data,
  input  wire logic        capture_bit_clock,
  input  wire logic        capture_word_select,
  input  wire logic        capture_serial_in,
  input  wire logic        playback_bit_clock,
  input  wire logic        playback_word_select,
  input  wire logic        playback_serial_out,
  output logic             conv_bit_clock,
  output logic             conv_word_select,
  output logic             conv_serial_in,
  output logic             hw_req,
  output logic [31:0]      hw_addr,
  input  wire logic        hw_gnt,
  output logic             hw_wvalid,
  output logic [31:0]      hw_wdata,
  input  wire logic        global_power_down,
  output logic             capture_irq
);
  import acdma_pkg::*;
  localparam int WIDX = $clog2(WORDS);
  // ----------------------------------------------------------------------
  // register bus decode
  // ----------------------------------------------------------------------
  logic                wr_acc, wr_ctl, soft_rst, clr, mapped;
  logic [3:0]          ack;
  logic [31:0]         rd_nxt;
  logic                loop_r, awake_r, capon_r;
  logic [3:0]          en_r;
  logic [3:0]          flag_r;
  logic [31:0]         first_buffer_start_r, second_buffer_start_r, size_r;
  // writes land only at the access edge
  assign wr_acc   = psel & penable & pwrite;
  assign wr_ctl   = wr_acc & (paddr == ACDMA_CTL_OFS);
  assign soft_rst = wr_ctl & pwdata[ACDMA_RESET_BIT];     // R10
  assign clr      = ~rst_b | soft_rst;                    // R10
  assign ack      = wr_ctl ? pwdata[ACDMA_ACK_LSB +: 4] : 4'h0;
  assign mapped   = (paddr == ACDMA_CTL_OFS) | (paddr == ACDMA_FIRST_BUFFER_START_OFS) |
                    (paddr == ACDMA_SECOND_BUFFER_START_OFS) | (paddr == ACDMA_SIZE_OFS);
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~mapped;

  // ----------------------------------------------------------------------
  // capture engine state
  // ----------------------------------------------------------------------
  logic                active, arrive, bw_hit, starve_hit, burst_done;
  logic                hold_full_r, pending_r, cur_first_r, avail1_r, avail2_r;
  logic                halt_bw_r, halt_ovr_r, cur_avail, stage_go, last_sample;
  logic [31:0]         hold_r, burst_addr_r, cnt_r;
  logic [31:0]         stage_r [WORDS];
  logic [WIDX-1:0]     widx_r, beat_r;
  acdma_wr_t           wst_r;
  // power down stops the unit unless stay_awake is set
  assign active      = capon_r & ~(global_power_down & ~awake_r);  // R11 R12
  assign arrive      = sample_valid & active & ~halt_bw_r & ~halt_ovr_r; // R14
  assign bw_hit      = arrive & hold_full_r & pending_r;            // R4
  assign cur_avail   = cur_first_r ? avail1_r : avail2_r;
  assign stage_go    = hold_full_r & ~pending_r & cur_avail;        // R1
  assign starve_hit  = hold_full_r & ~pending_r & ~cur_avail;       // R8
  assign last_sample = (cnt_r + 32'h1) == size_r;                   // R23
  assign burst_done  = (wst_r == ACDMA_WR_BURST) && (beat_r == WIDX'(WORDS - 1));

  // ----------------------------------------------------------------------
  // control, base and size registers
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (clr)
    begin
      loop_r  <= 1'b0;                                   // R20
      awake_r <= 1'b0;
      capon_r <= 1'b0;
      en_r    <= 4'h0;                                   // R9
      first_buffer_start_r <= ACDMA_ZERO_RST;
      second_buffer_start_r <= ACDMA_ZERO_RST;
      size_r  <= ACDMA_ZERO_RST;
    end
    else if (wr_acc)
    begin
      case (paddr)
        ACDMA_CTL_OFS:
        begin
          loop_r  <= pwdata[ACDMA_LOOP_BIT];             // R20
          awake_r <= pwdata[ACDMA_AWAKE_BIT];            // R12
          capon_r <= pwdata[ACDMA_CAPON_BIT];            // R11
          en_r    <= pwdata[ACDMA_EN_LSB +: 4];
        end
        ACDMA_FIRST_BUFFER_START_OFS: first_buffer_start_r <= pwdata & ACDMA_ALIGN_MSK;
        ACDMA_SECOND_BUFFER_START_OFS: second_buffer_start_r <= pwdata & ACDMA_ALIGN_MSK;
        ACDMA_SIZE_OFS:  size_r  <= pwdata & ACDMA_ALIGN_MSK;
        default:         ;
      endcase
    end
  end

  // read data, registered in the setup cycle
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    case (paddr)
      ACDMA_CTL_OFS:
      begin
        // reset and clear bits always read as zero
        rd_nxt[ACDMA_LOOP_BIT]         = loop_r;         // R10 R13
        rd_nxt[ACDMA_AWAKE_BIT]        = awake_r;
        rd_nxt[ACDMA_CAPON_BIT]        = capon_r;
        rd_nxt[ACDMA_EN_LSB +: 4]      = en_r;
        rd_nxt[ACDMA_CUR_BIT]          = cur_first_r;    // R5
        rd_nxt[ACDMA_FLAG_LSB +: 4]    = flag_r;
      end
      ACDMA_FIRST_BUFFER_START_OFS: rd_nxt = first_buffer_start_r;
      ACDMA_SECOND_BUFFER_START_OFS: rd_nxt = second_buffer_start_r;
      ACDMA_SIZE_OFS:  rd_nxt = size_r;
      default:         rd_nxt = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge core_clk)
  begin
    if (clr)
      prdata <= 32'h0000_0000;
    else if (psel & ~penable & ~pwrite)
      prdata <= rd_nxt;
  end

  // ----------------------------------------------------------------------
  // sticky flags: a set in the clearing cycle wins
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (clr)
      flag_r <= 4'h0;
    else
    begin
      if (stage_go & last_sample & cur_first_r)
        flag_r[ACDMA_F_FIRST] <= 1'b1;                   // R6
      else if (ack[ACDMA_F_FIRST])
        flag_r[ACDMA_F_FIRST] <= 1'b0;                   // R13
      if (stage_go & last_sample & ~cur_first_r)
        flag_r[ACDMA_F_SECOND] <= 1'b1;                  // R7
      else if (ack[ACDMA_F_SECOND])
        flag_r[ACDMA_F_SECOND] <= 1'b0;                  // R13
      if (bw_hit)
        flag_r[ACDMA_F_BW] <= 1'b1;                      // R4 R17
      else if (ack[ACDMA_F_BW])
        flag_r[ACDMA_F_BW] <= 1'b0;
      if (starve_hit)
        flag_r[ACDMA_F_STARV] <= 1'b1;                   // R8 R17
      else if (ack[ACDMA_F_STARV])
        flag_r[ACDMA_F_STARV] <= 1'b0;
    end
  end
  // one shared level request; acks drop it the next edge
  assign capture_irq = |(flag_r & en_r);                 // R24 R9

  // ----------------------------------------------------------------------
  // holding register and error halts
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (clr)
    begin
      hold_full_r <= 1'b0;
      hold_r      <= 32'h0000_0000;
    end
    else if (arrive & ~bw_hit)
    begin
      hold_full_r <= 1'b1;                               // R1
      hold_r      <= sample_data;
    end
    else if (stage_go | starve_hit)
      hold_full_r <= 1'b0;                               // R14
  end
  always_ff @(posedge core_clk)
  begin
    if (clr)
    begin
      halt_bw_r  <= 1'b0;
      halt_ovr_r <= 1'b0;
    end
    else
    begin
      if (bw_hit)
        halt_bw_r <= 1'b1;                               // R14
      else if (burst_done)
        halt_bw_r <= 1'b0;                               // R16
      if (starve_hit)
        halt_ovr_r <= 1'b1;                              // R14
      else if (ack[ACDMA_F_FIRST] | ack[ACDMA_F_SECOND])
        halt_ovr_r <= 1'b0;                              // R15
    end
  end

  // ----------------------------------------------------------------------
  // ping-pong bookkeeping; both buffers count as supplied after reset
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (clr)
    begin
      cur_first_r <= 1'b1;                               // R5
      cnt_r       <= 32'h0000_0000;
      avail1_r    <= 1'b1;
      avail2_r    <= 1'b1;
    end
    else
    begin
      if (stage_go)
      begin
        if (last_sample)
        begin
          cnt_r       <= 32'h0000_0000;
          cur_first_r <= ~cur_first_r;                   // R21
        end
        else
          cnt_r <= cnt_r + 32'h1;                        // R23
      end
      if (ack[ACDMA_F_FIRST])
        avail1_r <= 1'b1;                                // R6
      else if (stage_go & last_sample & cur_first_r)
        avail1_r <= 1'b0;
      if (ack[ACDMA_F_SECOND])
        avail2_r <= 1'b1;                                // R7
      else if (stage_go & last_sample & ~cur_first_r)
        avail2_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // staging buffer fill
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (clr)
    begin
      widx_r       <= '0;
      pending_r    <= 1'b0;
      burst_addr_r <= 32'h0000_0000;
    end
    else
    begin
      if (stage_go)
      begin
        widx_r <= widx_r + 1'b1;
        if (widx_r == '0)
          burst_addr_r <= (cur_first_r ? first_buffer_start_r : second_buffer_start_r) + {cnt_r[29:0], 2'b00};
        if (widx_r == WIDX'(WORDS - 1))
          pending_r <= 1'b1;                             // R2
      end
      if (burst_done)
        pending_r <= 1'b0;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < WORDS; gi++)
    begin : g_stage
      always_ff @(posedge core_clk)
      begin
        if (clr)
          stage_r[gi] <= 32'h0000_0000;
        else if (stage_go && (widx_r == WIDX'(gi)))
          stage_r[gi] <= hold_r;                         // R1
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // highway burst: one request, then one word per cycle
  // ----------------------------------------------------------------------
  // the hold register takes the next sample meanwhile, which is what gives
  // the arbiter one whole sample interval to answer
  always_ff @(posedge core_clk)
  begin
    if (clr)
    begin
      wst_r    <= ACDMA_WR_IDLE;
      beat_r   <= '0;
      hw_wdata <= 32'h0000_0000;
    end
    else
    begin
      case (wst_r)
        ACDMA_WR_IDLE:
          if (pending_r & active)
            wst_r <= ACDMA_WR_REQ;                       // R2 R11
        ACDMA_WR_REQ:
          if (hw_gnt)
          begin
            wst_r    <= ACDMA_WR_BURST;
            beat_r   <= '0;
            hw_wdata <= stage_r[0];
          end
        ACDMA_WR_BURST:
        begin
          beat_r   <= beat_r + 1'b1;
          hw_wdata <= stage_r[WIDX'(beat_r + 1'b1)];
          if (burst_done)
            wst_r <= ACDMA_WR_IDLE;
        end
        default: wst_r <= ACDMA_WR_IDLE;
      endcase
    end
  end
  assign hw_req    = (wst_r == ACDMA_WR_REQ);
  assign hw_addr   = burst_addr_r;
  assign hw_wvalid = (wst_r == ACDMA_WR_BURST);

  // converter pin selection: a pin driven from the board defeats the playback test
  assign conv_bit_clock   = loop_r ? playback_bit_clock   : capture_bit_clock;   // R18
  assign conv_word_select = loop_r ? playback_word_select : capture_word_select; // R18
  assign conv_serial_in   = loop_r ? playback_serial_out  : capture_serial_in;   // R18

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  bw_error_set_a: assert property (bw_hit |=> flag_r[ACDMA_F_BW]) // R4
    else $error("bandwidth error not flagged");
  cur_after_rst_a: assert property (soft_rst |=> cur_first_r && !flag_r[0]) // R5
    else $error("buffer one not current after reset");
  first_clear_a: assert property (ack[0] && !(stage_go && last_sample && cur_first_r) // R13
    |=> !flag_r[0] ##0 !(capture_irq && flag_r == 4'h1))
    else $error("first flag not cleared");
  starved_sticky_a: assert property (flag_r[ACDMA_F_STARV] && !ack[ACDMA_F_STARV] // R17
    && !soft_rst |=> flag_r[ACDMA_F_STARV])
    else $error("starved flag lost");
  halt_discard_a: assert property ((halt_bw_r || halt_ovr_r) && sample_valid // R14
    && !hold_full_r |=> !hold_full_r)
    else $error("sample taken while halted");
  bw_resume_a: assert property (halt_bw_r && burst_done && !soft_rst |=> !halt_bw_r) // R16
    else $error("bandwidth halt did not end");
  ovr_resume_a: assert property (halt_ovr_r && (|ack[1:0]) |=> !halt_ovr_r) // R15
    else $error("starved halt did not end");
  burst_len_a: assert property ($rose(hw_wvalid) && !soft_rst |-> hw_wvalid[*8] ##1 // R2
    hw_wvalid[*8] ##1 !hw_wvalid)
    else $error("burst not sixteen words");
  irq_level_a: assert property (flag_r[ACDMA_F_BW] && en_r[ACDMA_F_BW] |-> capture_irq) // R9
    else $error("bandwidth irq missing");
  idle_off_a: assert property (!active && !hold_full_r && !soft_rst |=> !hold_full_r) // R11
    else $error("capture while inactive");
  rst_bit_zero_a: assert property (psel && penable |-> !prdata[ACDMA_RESET_BIT]) // R10
    else $error("reset bit read as one");
  bw_event_c:   cover property (bw_hit);
  starve_c:     cover property (starve_hit);
  swap_c:       cover property (flag_r[0] ##[1:1000] flag_r[1]);
  burst_c:      cover property (burst_done);

endmodule

// ===== acdma_pkg.sv
/*
  Package for the audio capture DMA block: register offsets, control and
  status field positions, reset values and the staging buffer geometry.
  Assumes a 32-bit APB register bus and a 32-bit highway write port.
*/
package acdma_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] ACDMA_CTL_OFS   = 8'h00; // capture_control_status
  localparam logic [7:0] ACDMA_FIRST_BUFFER_START_OFS = 8'h04; // first_buffer_start
  localparam logic [7:0] ACDMA_SECOND_BUFFER_START_OFS = 8'h08; // second_buffer_start
  localparam logic [7:0] ACDMA_SIZE_OFS  = 8'h0C; // samples per buffer

  // ----------------------------------------------------------------------
  // capture_control_status fields
  // ----------------------------------------------------------------------
  localparam int ACDMA_RESET_BIT   = 31;
  localparam int ACDMA_LOOP_BIT    = 30; // loopback_diagnostic
  localparam int ACDMA_AWAKE_BIT   = 29; // stay_awake
  localparam int ACDMA_CAPON_BIT   = 28; // capture_on
  localparam int ACDMA_EN_LSB      = 24; // four irq enables
  localparam int ACDMA_ACK_LSB     = 20; // four release / clear bits
  localparam int ACDMA_CUR_BIT     = 4;  // first_buffer_current
  localparam int ACDMA_FLAG_LSB    = 0;  // four status flags
  localparam int ACDMA_NFLAG       = 4;

  // flag order inside each group of four
  localparam int ACDMA_F_FIRST  = 0; // first_buffer_filled
  localparam int ACDMA_F_SECOND = 1; // second_buffer_filled
  localparam int ACDMA_F_BW     = 2; // highway_bandwidth_error
  localparam int ACDMA_F_STARV  = 3; // buffer starved

  // ----------------------------------------------------------------------
  // reset values and geometry
  // ----------------------------------------------------------------------
  localparam logic [31:0] ACDMA_ZERO_RST  = 32'h0000_0000;
  localparam logic [31:0] ACDMA_ALIGN_MSK = 32'hFFFF_FFC0; // low six bits zero
  localparam int          ACDMA_BUF_BYTES = 64;
  localparam int          ACDMA_BUF_WORDS = ACDMA_BUF_BYTES / 4;

  typedef enum logic [1:0] {ACDMA_WR_IDLE, ACDMA_WR_REQ, ACDMA_WR_BURST} acdma_wr_t;

endpackage

// ===== acdma_hw_model.sv
/*
  highway arbiter and sdram model for the capture dma test.
  assumes one grant per request, then sixteen words, one per cycle.
*/
`timescale 1ns/10ps
module acdma_hw_model (
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        hw_req,
  input  wire logic [31:0] hw_addr,
  input  wire logic        hw_wvalid,
  input  wire logic [31:0] hw_wdata,
  input  wire logic [7:0]  gnt_delay,
  output logic             hw_gnt,
  output logic [7:0]       bursts
);
  // ------------------------------------------------------------
  // arbiter and memory
  // ------------------------------------------------------------
  logic [31:0] mem [0:255];
  logic [7:0]  wait_r;
  logic [7:0]  ptr_r;

  // grant after a settable wait; a long wait provokes lost samples
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      wait_r <= 8'h00;
      hw_gnt <= 1'b0;
      bursts <= 8'h00;
    end
    else
    begin
      wait_r <= (hw_req && !hw_gnt) ? wait_r + 8'h01 : 8'h00;
      hw_gnt <= hw_req && !hw_gnt && (wait_r >= gnt_delay);
      if (hw_req && hw_gnt)
        bursts <= bursts + 8'h01;
    end
  end

  // store words at consecutive word addresses from the burst base
  always_ff @(posedge core_clk)
  begin
    if (hw_req && hw_gnt)
      ptr_r <= hw_addr[9:2];
    else if (hw_wvalid)
    begin
      mem[ptr_r] <= hw_wdata;
      ptr_r      <= ptr_r + 8'h01;
    end
  end
endmodule

// ===== tb_audio_capture_dma_status.sv
/*
  testbench for the capture dma: apb master, sample source, pins.
  assumes the highway model file and a zero wait state apb slave.
*/
`timescale 1ns/10ps
module tb_audio_capture_dma_status;
  import acdma_pkg::*;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic        core_clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic        sample_valid, hw_req, hw_gnt, hw_wvalid, gpd, capture_irq, err;
  logic [7:0]  paddr, gnt_delay, bursts, b0;
  logic [31:0] pwdata, prdata, sample_data, hw_addr, hw_wdata, rd, ctl;
  logic [5:0]  pins;
  logic [2:0]  conv;
  logic [31:0] sent [$];
  int          bad_count, check_count;

  acdma_top dut (
    .core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
    .sample_data(sample_data), .capture_bit_clock(pins[0]),
    .capture_word_select(pins[1]), .capture_serial_in(pins[2]),
    .playback_bit_clock(pins[3]), .playback_word_select(pins[4]),
    .playback_serial_out(pins[5]), .conv_bit_clock(conv[0]),
    .conv_word_select(conv[1]), .conv_serial_in(conv[2]), .hw_req(hw_req),
    .hw_addr(hw_addr), .hw_gnt(hw_gnt), .hw_wvalid(hw_wvalid),
    .hw_wdata(hw_wdata), .global_power_down(gpd), .capture_irq(capture_irq));

  acdma_hw_model u_hw (
    .core_clk(core_clk), .rst_b(rst_b), .hw_req(hw_req), .hw_addr(hw_addr),
    .hw_wvalid(hw_wvalid), .hw_wdata(hw_wdata), .gnt_delay(gnt_delay),
    .hw_gnt(hw_gnt), .bursts(bursts));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // expected control/status word: ack and reset bits always read zero
  function automatic logic [31:0] stat(input logic [31:0] c, input logic [3:0] f);
    return (c & 32'h7F00_0000) | {27'h0, 1'b1, f};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      bad_count++;
      wrap_up();
    end
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // random samples, one cycle pulses, remembered for comparison
  task automatic send(input int n, input int gap);
    logic [31:0] v;
    repeat (n)
    begin
      @(posedge core_clk);
      v = $urandom;
      sample_valid <= 1'b1;
      sample_data  <= v;
      sent.push_back(v);
      @(posedge core_clk);
      sample_valid <= 1'b0;
      repeat (gap) @(posedge core_clk);
    end
  endtask

  // bounded wait until no burst is requested or running
  task automatic wait_idle();
    int n;
    repeat (3) @(posedge core_clk);
    n = 0;
    while ((hw_req !== 1'b0 || hw_wvalid !== 1'b0) && n < 500)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 500)
    begin
      bad_count++;
      wrap_up();
    end
  endtask

  task automatic setup_bufs();
    apb(1'b1, ACDMA_FIRST_BUFFER_START_OFS, 32'h0000_007F);
    apb(1'b1, ACDMA_SECOND_BUFFER_START_OFS, 32'h0000_0200);
    apb(1'b1, ACDMA_SIZE_OFS, 32'h0000_0040);
  endtask

  initial
  begin
    repeat (100000) @(posedge core_clk);
    bad_count++;
    wrap_up();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    {psel, penable, pwrite, sample_valid, gpd, rst_b} = 6'h00;
    {paddr, gnt_delay, pins} = 22'h0;
    {pwdata, sample_data} = 64'h0;
    bad_count = 0;
    check_count = 0;
    void'($urandom(20));
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    apb(1'b0, ACDMA_CTL_OFS, 32'h0);
    check(rd, 32'h0000_0010);
    apb(1'b0, 8'h10, 32'h0);
    check({31'h0, err}, 32'h1);
    setup_bufs();
    apb(1'b0, ACDMA_FIRST_BUFFER_START_OFS, 32'h0);
    check(rd, 32'h0000_0040);
    send(16, 2);
    wait_idle();
    check({24'h0, bursts}, 32'h0);
    // ping-pong fill with every interrupt enabled
    sent.delete();
    ctl = 32'h1F00_0000;
    apb(1'b1, ACDMA_CTL_OFS, ctl);
    gnt_delay <= 8'($urandom % 8);
    send(128, 18);
    wait_idle();
    for (int i = 0; i < 64; i++)
    begin
      check(u_hw.mem[16 + i], sent[i]);
      check(u_hw.mem[128 + i], sent[64 + i]);
    end
    apb(1'b0, ACDMA_CTL_OFS, 32'h0);
    check(rd, stat(ctl, 4'b0011));
    check({31'h0, capture_irq}, 32'h1);
    // no free buffer: starve, samples lost until a release
    b0 = bursts;
    send(17, 18);
    wait_idle();
    check({24'h0, bursts}, {24'h0, b0});
    apb(1'b0, ACDMA_CTL_OFS, 32'h0);
    check(rd, stat(ctl, 4'b1011));
    apb(1'b1, ACDMA_CTL_OFS, ctl | 32'h0010_0000);
    apb(1'b0, ACDMA_CTL_OFS, 32'h0);
    check(rd, stat(ctl, 4'b1010));
    sent.delete();
    send(16, 18);
    wait_idle();
    check({24'h0, bursts}, {24'h0, b0 + 8'h01});
    check(u_hw.mem[16], sent[0]);
    apb(1'b1, ACDMA_CTL_OFS, ctl | 32'h00A0_0000);
    apb(1'b0, ACDMA_CTL_OFS, 32'h0);
    check(rd, stat(ctl, 4'b0000));
    check({31'h0, capture_irq}, 32'h0);
    // soft reset, other bits of that write are ignored
    apb(1'b1, ACDMA_CTL_OFS, 32'h8000_0000 | ctl);
    apb(1'b0, ACDMA_CTL_OFS, 32'h0);
    check(rd, 32'h0000_0010);
    apb(1'b0, ACDMA_SECOND_BUFFER_START_OFS, 32'h0);
    check(rd, 32'h0);
    // slow grant: bandwidth error, halt until the burst is written
    setup_bufs();
    ctl = 32'h1400_0000;
    apb(1'b1, ACDMA_CTL_OFS, ctl);
    gnt_delay <= 8'd80;
    b0 = bursts;
    send(18, 0);
    apb(1'b0, ACDMA_CTL_OFS, 32'h0);
    check(rd, stat(ctl, 4'b0100));
    check({31'h0, capture_irq}, 32'h1);
    wait_idle();
    gnt_delay <= 8'd0;
    send(16, 18);
    wait_idle();
    check({24'h0, bursts}, {24'h0, b0 + 8'h02});
    apb(1'b0, ACDMA_CTL_OFS, 32'h0);
    check(rd, stat(ctl, 4'b0100));
    apb(1'b1, ACDMA_CTL_OFS, ctl | 32'h0040_0000);
    @(posedge core_clk);
    check({31'h0, capture_irq}, 32'h0);
    // global power down stops the unit unless it stays awake
    gpd <= 1'b1;
    b0 = bursts;
    send(16, 18);
    wait_idle();
    check({24'h0, bursts}, {24'h0, b0});
    ctl = ctl | 32'h2000_0000;
    apb(1'b1, ACDMA_CTL_OFS, ctl);
    send(16, 18);
    wait_idle();
    check({24'h0, bursts}, {24'h0, b0 + 8'h01});
    gpd <= 1'b0;
    // loopback entry: set, wait, soft reset, set again
    apb(1'b1, ACDMA_CTL_OFS, 32'h4000_0000);
    repeat (5) @(posedge core_clk);
    apb(1'b1, ACDMA_CTL_OFS, 32'h8000_0000);
    for (int i = 0; i < 8; i++)
    begin
      pins <= 6'($urandom);
      apb(1'b1, ACDMA_CTL_OFS, (i % 2 == 0) ? 32'h4000_0000 : 32'h0);
      @(posedge core_clk);
      check({29'h0, conv}, {29'h0, (i % 2 == 0) ? pins[5:3] : pins[2:0]});
    end
    wrap_up();
  end
endmodule
